// ==== verilog/inclinometer_spi_readout.sv ====
// Serial slave readout with conversion timing, start-up check and self test control
//
// How it works
// - One conversion takes 150 us
// - Start-up reset and parity check, 10 ms
// - A lone self-test pin high starts its channel self test
// - Inclination samples are 12 bits wide
// - Zero acceleration gives code 1024
// - Gain 6554 or 3277 codes per g
// - Select high releases data output
// - Memory parity checked continuously
// - Sensing element interconnect checked continuously
// - Serial link returns X, Y, temperature
// - MSB first, shift on fall, sample rise
// - First eight bits form the command
// - Select rise clears counter and command
// - Command codes 10h, 11h and 08h
`timescale 1ns/1ps
module inclinometer_spi_readout #(
   parameter int STARTUP_CYC = incl_pkg::STARTUP_CYCLES,
   parameter int CONV_CYC    = incl_pkg::CONV_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   clk_en,
   input  wire logic                   wide_range,
   input  wire logic signed [15:0]     accel_x_mg,
   input  wire logic signed [15:0]     accel_y_mg,
   input  wire logic [7:0]             temp_raw,
   input  wire logic [7:0]             nv_memory,
   input  wire logic                   nv_parity,
   input  wire logic                   element_open,
   input  wire logic                   selftest_in_ch1,
   input  wire logic                   selftest_in_ch2,
   output      logic                   selftest_drive_ch1,
   output      logic                   selftest_drive_ch2,
   output      logic                   device_ready,
   output      logic                   fault,
   input  wire logic                   sck,
   input  wire logic                   select_low,
   input  wire logic                   mosi,
   output      logic                   miso_out,
   output      logic                   miso_oe
);
   // ==========================================
   // Pin synchronisers on the core clock
   logic [1:0] st1_s_r;
   logic [1:0] st2_s_r;
   logic [1:0] sel_s_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st1_s_r <= 2'h0;
         st2_s_r <= 2'h0;
         sel_s_r <= 2'h3;
      end else if (clk_en) begin
         st1_s_r <= {st1_s_r[0], selftest_in_ch1};
         st2_s_r <= {st2_s_r[0], selftest_in_ch2};
         sel_s_r <= {sel_s_r[0], select_low};
      end
   end

   // ==========================================
   // Start-up check, then continuous monitoring
   logic [31:0] start_cnt_r;
   logic        ready_r;
   logic        fault_r;
   wire         parity_bad = ^{nv_memory, nv_parity};
   wire         start_done = (start_cnt_r >= 32'(STARTUP_CYC - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         start_cnt_r <= 32'h0;
         ready_r     <= 1'b0;
         fault_r     <= 1'b0;
      end else if (clk_en) begin
         if (!ready_r) begin
            start_cnt_r <= start_cnt_r + 32'h1;
            ready_r     <= start_done;
         end
         // Live level, not sticky: a cleared cause drops the flag
         fault_r <= parity_bad | element_open;
      end
   end
   assign device_ready = ready_r;
   assign fault        = fault_r;

   // ==========================================
   // Self test: a lone request deflects its channel; both at once is ignored
   logic st1_r;
   logic st2_r;
   // Opposite deflections at once would mask each other, so both are dropped
   wire  st_both = st1_s_r[1] & st2_s_r[1];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st1_r <= 1'b0;
         st2_r <= 1'b0;
      end else if (clk_en) begin
         st1_r <= st1_s_r[1] & ~st_both;
         st2_r <= st2_s_r[1] & ~st_both;
      end
   end
   assign selftest_drive_ch1 = st1_r;
   assign selftest_drive_ch2 = st2_r;

   // ==========================================
   // Conversion: 12-bit code = 1024 + g * gain
   function automatic logic signed [31:0] gain_of(input logic wide);
      if (wide)
         gain_of = $signed({16'h0, incl_pkg::WIDE_LSB_PER_G});
      else
         gain_of = $signed({16'h0, incl_pkg::NARROW_LSB_PER_G});
   endfunction : gain_of

   // Saturate rather than wrap so a hard tilt never reads as the opposite side
   function automatic logic [11:0] clip12(input logic signed [31:0] v);
      if (v < 0)
         clip12 = 12'h000;
      else if (v > 32'sh0fff)
         clip12 = 12'hfff;
      else
         clip12 = v[11:0];
   endfunction : clip12

   function automatic logic [11:0] to_code(input logic signed [15:0] mg, input logic wide);
      logic signed [31:0] prod;
      logic signed [31:0] code;
      prod    = mg * gain_of(wide);
      code    = 32'(prod / incl_pkg::MG_PER_G) + $signed({20'h0, incl_pkg::ZERO_G_CODE});
      to_code = clip12(code);
   endfunction : to_code

   function automatic logic cmd_match(input logic [7:0] c, input logic [7:0] code);
      cmd_match = (c == code);
   endfunction : cmd_match

   logic [31:0]                  conv_cnt_r;
   incl_pkg::sample_set_type     result_r;
   wire                          conv_done = (conv_cnt_r >= 32'(CONV_CYC - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conv_cnt_r <= 32'h0;
         result_r   <= '0;
      end else if (clk_en) begin
         conv_cnt_r <= conv_done ? 32'h0 : conv_cnt_r + 32'h1;
         // Only finished conversions reach the readout copy
         if (conv_done && ready_r) begin
            result_r.x    <= to_code(accel_x_mg, wide_range);
            result_r.y    <= to_code(accel_y_mg, wide_range);
            result_r.temp <= temp_raw;
         end
      end
   end

   // Snapshot held while selected so the link sees a still word
   incl_pkg::sample_set_type snap_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         snap_r <= '0;
      end else if (clk_en && sel_s_r[1]) begin
         snap_r <= result_r;
      end
   end
   // Slow serial clock gives many core cycles between select fall and first word use

   // ==========================================
   // Link domain on the serial clock
   logic [4:0]  bitcnt_r;
   logic [7:0]  cmd_r;
   logic [11:0] shift_r;
   logic        out_bit_r;
   logic        talk_r;
   wire  [7:0]  cmd_full = {cmd_r[6:0], mosi};
   wire         is_x = cmd_match(cmd_full, incl_pkg::READ_X_SAMPLE_CMD);
   wire         is_y = cmd_match(cmd_full, incl_pkg::READ_Y_SAMPLE_CMD);
   wire         is_t = cmd_match(cmd_full, incl_pkg::TEMP_REGISTER_ACCESS_CMD);
   wire         last_cmd_bit = (bitcnt_r == 5'(incl_pkg::CMD_BITS - 1));
   wire  [11:0] load_word = is_x ? snap_r.x :
                            is_y ? snap_r.y :
                            {snap_r.temp, 4'h0};

   // Select high acts as asynchronous clear, since the link clock stops between frames
   // Link logic ignores clk_en: the master owns that clock and may run while the core is frozen
   always_ff @(posedge sck or posedge select_low) begin
      if (select_low) begin
         bitcnt_r <= 5'h0;
         cmd_r    <= 8'h00;
         shift_r  <= 12'h000;
         talk_r   <= 1'b0;
      end else begin
         if (bitcnt_r != incl_pkg::BITCNT_MAX)
            bitcnt_r <= bitcnt_r + 5'h1;
         if (bitcnt_r < 5'(incl_pkg::CMD_BITS))
            cmd_r <= cmd_full;
         if (last_cmd_bit) begin
            talk_r  <= is_x | is_y | is_t;
            shift_r <= load_word;
         end else begin
            // Bits after the twelfth shift out zero
            shift_r <= {shift_r[10:0], 1'b0};
         end
      end
   end

   always_ff @(negedge sck or posedge select_low) begin
      if (select_low) begin
         out_bit_r <= 1'b0;
         miso_oe   <= 1'b0;
      end else begin
         out_bit_r <= shift_r[11];
         miso_oe   <= talk_r;
      end
   end
   assign miso_out = out_bit_r;
endmodule : inclinometer_spi_readout

// ==== verilog/incl_pkg.sv ====
// Package with constants and carrier types for the inclinometer serial readout
package incl_pkg;
   // ==========================================
   // Timing
   localparam int          CLK_MHZ          = 50;
   localparam int          CONV_TIME_US     = 150;
   localparam int          CONV_CYCLES      = CONV_TIME_US * CLK_MHZ;
   localparam int          STARTUP_TIME_MS  = 10;
   localparam int          STARTUP_CYCLES   = STARTUP_TIME_MS * 1000 * CLK_MHZ;
   localparam int          MG_PER_G         = 1000;
   // ==========================================
   // Command codes and frame layout
   localparam logic [7:0]  READ_X_SAMPLE_CMD         = 8'h10;
   localparam logic [7:0]  READ_Y_SAMPLE_CMD         = 8'h11;
   localparam logic [7:0]  TEMP_REGISTER_ACCESS_CMD  = 8'h08;
   localparam int          CMD_BITS         = 8;
   localparam int          SAMPLE_BITS      = 12;
   localparam int          TEMP_BITS        = 8;
   localparam logic [11:0] ZERO_G_CODE      = 12'h400;
   // Narrow gain needs more than 12 bits
   localparam logic [15:0] NARROW_LSB_PER_G = 16'h199a;
   localparam logic [15:0] WIDE_LSB_PER_G   = 16'h0ccd;
   localparam logic [4:0]  BITCNT_MAX       = 5'h1f;
   // ==========================================
   // Carrier types
   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [7:0]  temp;
   } sample_set_type;

   typedef struct packed {
      logic oe;
      logic data;
   } miso_drive_type;
endpackage : incl_pkg

// ==== testbench/inclinometer_spi_readout_assertions.sv ====
// Port checks of the inclinometer serial readout
`timescale 1ns/1ps
module inclinometer_spi_readout_assertions #(parameter int STARTUP_CYC = 50) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic element_open,
   input wire logic fault,
   input wire logic selftest_in_ch1,
   input wire logic selftest_in_ch2,
   input wire logic selftest_drive_ch1,
   input wire logic selftest_drive_ch2,
   input wire logic device_ready,
   input wire logic sck,
   input wire logic select_low,
   input wire logic miso_oe
);
   int         n_r;
   logic [4:0] bits_r;
   // ==========
   // Helpers: edges since reset, serial rises in the frame
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) n_r <= 0; else if (n_r < 9999) n_r <= n_r + 1;
   always_ff @(posedge sck or posedge select_low)
      if (select_low) bits_r <= 5'h00; else if (bits_r < 5'h1f) bits_r <= bits_r + 5'h01;
   // Three edges cover the two-stage pin sync plus the output register
   sequence st_only(a, b); (a && !b) [*3]; endsequence
   // ==========
   // Properties
   AST_ST1: assert property (@(posedge clk) disable iff (!rstn)
      st_only(selftest_in_ch1, selftest_in_ch2) |=> selftest_drive_ch1) else $error("st1");
   AST_ST2: assert property (@(posedge clk) disable iff (!rstn)
      st_only(selftest_in_ch2, selftest_in_ch1) |=> selftest_drive_ch2) else $error("st2");
   AST_ST_NONE: assert property (@(posedge clk) disable iff (!rstn)
      !(selftest_drive_ch1 && selftest_drive_ch2)) else $error("st both");
   AST_RDY_LOW: assert property (@(posedge clk) disable iff (!rstn)
      n_r < STARTUP_CYC - 1 |-> !device_ready) else $error("ready early");
   AST_RDY_HIGH: assert property (@(posedge clk) disable iff (!rstn)
      n_r > STARTUP_CYC + 1 |-> device_ready) else $error("ready late");
   AST_RDY_STAY: assert property (@(posedge clk) disable iff (!rstn)
      device_ready |=> device_ready) else $error("ready lost");
   AST_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
      select_low && $past(select_low) |-> !miso_oe) else $error("miso held");
   AST_CMD_QUIET: assert property (@(negedge sck) disable iff (select_low)
      bits_r <= 5'h08 |-> !miso_oe) else $error("miso early");
   AST_FAULT: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && element_open |=> fault) else $error("fault missing");
endmodule : inclinometer_spi_readout_assertions
bind inclinometer_spi_readout inclinometer_spi_readout_assertions
   #(.STARTUP_CYC(STARTUP_CYC)) inclinometer_spi_readout_assertions_i (.*);

// ==== testbench/incl_spi_master.sv ====
// Serial master model that runs read frames
`timescale 1ns/1ps
module incl_spi_master (
   output logic      sck,
   output logic      select_low,
   output logic      mosi,
   input  wire logic miso_out,
   input  wire logic miso_oe
);
   // Select rises once at start so the link logic leaves its unknown state
   initial begin
      {sck, select_low, mosi} = 3'b000;
      #1 select_low = 1'b1;
   end
   // Link clock runs only inside a frame, 12 ns period, fast to keep runs short
   task automatic xfer(input logic [7:0] c, output logic [11:0] w, output logic oe);
      oe = 1'b1;
      select_low = 1'b0;
      for (int i = 0; i < 20; i++) begin
         mosi = (i < 8) ? c[7 - i] : 1'b0;
         #6 sck = 1'b1;
         if (i > 7) {w[19 - i], oe} = {miso_oe & miso_out, oe & miso_oe};
         #6 sck = 1'b0;
      end
      #6 select_low = 1'b1;
   endtask : xfer
endmodule : incl_spi_master

// ==== testbench/tb_inclinometer_spi_readout.sv ====
// Bench of the inclinometer serial readout
`timescale 1ns/1ps
module tb_inclinometer_spi_readout;
   localparam int CV = 20;
   logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, wide_range = 1'b0, nv_parity = 1'b0;
   logic element_open = 1'b0, selftest_in_ch1 = 1'b0, selftest_in_ch2 = 1'b0, oe;
   logic selftest_drive_ch1, selftest_drive_ch2, device_ready, fault;
   logic sck, select_low, mosi, miso_out, miso_oe;
   logic signed [15:0] accel_x_mg = '0, accel_y_mg = 16'sd100;
   logic [7:0] temp_raw = 8'h5a, nv_memory = 8'h00;
   logic [11:0] w;
   int err_count = 0, num_checks = 0;
   always #10 clk = ~clk;
   inclinometer_spi_readout #(.STARTUP_CYC(50), .CONV_CYC(CV)) inclinometer_spi_readout_i (.*);
   incl_spi_master incl_spi_master_i (.*);
   task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : tick
   // Gap after a read lets a fresh conversion land
   task automatic rd(input logic [7:0] c, input logic [11:0] e);
      incl_spi_master_i.xfer(c, w, oe);
      chk("word", e, w);
      chk("oe", {11'h0, c != 8'h0a}, {11'h0, oe});
      tick(3 * CV);
   endtask : rd
   task automatic st(input logic a, input logic b, input logic [1:0] e);
      @(posedge clk) {selftest_in_ch1, selftest_in_ch2} <= {a, b};
      tick(4);
      chk("st", {10'h0, e}, {10'h0, selftest_drive_ch1, selftest_drive_ch2});
   endtask : st
   task automatic t_startup();
      for (int n = 0; n < 60 && device_ready !== 1'b1; n++) tick(1);
      chk("ready", 12'h001, {11'h0, device_ready});
      if (device_ready !== 1'b1) test_done();
      tick(3 * CV);
   endtask : t_startup
   task automatic t_reads();
      rd(8'h10, 12'h400);
      rd(8'h11, 12'h68f);
      rd(8'h08, 12'h5a0);
      rd(8'h0a, 12'h000);
      @(posedge clk) {wide_range, accel_x_mg} <= {1'b1, -16'sd2000};
      tick(3 * CV);
      rd(8'h11, 12'h547);
      rd(8'h10, 12'h000);
   endtask : t_reads
   task automatic t_selftest();
      st(1'b1, 1'b0, 2'b10);
      st(1'b1, 1'b1, 2'b00);
      st(1'b0, 1'b1, 2'b01);
   endtask : t_selftest
   task automatic t_fault();
      chk("fault", 12'h000, {11'h0, fault});
      @(posedge clk) element_open <= 1'b1;
      tick(2);
      chk("fault", 12'h001, {11'h0, fault});
      @(posedge clk) {element_open, nv_memory} <= {1'b0, 8'h01};
      tick(2);
      chk("fault", 12'h001, {11'h0, fault});
      @(posedge clk) nv_parity <= 1'b1;
      tick(2);
      chk("fault", 12'h000, {11'h0, fault});
   endtask : t_fault
   task automatic t_freeze();
      @(posedge clk) {clk_en, selftest_in_ch2} <= 2'b00;
      tick(4);
      chk("frozen", 12'h001, {10'h0, selftest_drive_ch1, selftest_drive_ch2});
      @(posedge clk) clk_en <= 1'b1;
      tick(4);
      chk("thawed", 12'h000, {10'h0, selftest_drive_ch1, selftest_drive_ch2});
   endtask : t_freeze
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_startup();
      t_reads();
      t_selftest();
      t_freeze();
      t_fault();
      test_done();
   end
endmodule : tb_inclinometer_spi_readout
